/* File: mpmc_defines.svh */
// Constants for the module power mode controller
`ifndef MPMC_DEFINES_SVH
`define MPMC_DEFINES_SVH

`define MPMC_ADDR_CTRL 12'h000
`define MPMC_ADDR_STATUS 12'h004
`define MPMC_ADDR_CLASS 12'h008
`define MPMC_CTRL_FLP_BIT 0
`define MPMC_CTRL_TXOVR_BIT 1
`define MPMC_FLP_DEFAULT 1'h0
`define MPMC_TXOVR_DEFAULT 1'h0
`define MPMC_CLASS_DEFAULT 3'h0
`define MPMC_HPLP_US 200
`define MPMC_CLK_MHZ 200
`define MPMC_HPLP_CYCLES (`MPMC_HPLP_US * `MPMC_CLK_MHZ)
`define MPMC_SYNC_STAGES 2
`define MPMC_DROP_CYCLES 16
`define MPMC_POWER_CLASS 3'h3
`define MPMC_HTRANS_NONSEQ 2'h2
`define MPMC_HSIZE_WORD 3'h2

`endif

/* File: mpmc_host_model.sv */
// Host board model driving the sideband pins
`timescale 1ns/10ps
`default_nettype none
module mpmc_host_model (
	input wire logic mclk, // Clock
	input wire logic want_rst, // Ask for reset
	input wire logic want_lp, // Ask for low power
	input wire logic [3:0] lag, // Cycles of delay
	output logic module_reset_in_n = 1'b0, // Reset pin
	output logic module_low_power_in_n = 1'b0 // Low-power pin
);
	logic [3:0] cnt_q = 4'h0;
	always @(posedge mclk) begin
		if ({module_reset_in_n, module_low_power_in_n} == {!want_rst, !want_lp}) cnt_q <= 4'h0;
		else if (cnt_q < lag) cnt_q <= cnt_q + 4'h1;
		else begin
			cnt_q <= 4'h0;
			module_reset_in_n <= !want_rst;
			module_low_power_in_n <= !want_lp;
		end
	end
endmodule
`default_nettype wire

/* File: mpmc_pkg.sv */
// Types for the module power mode controller
package mpmc_pkg;
	typedef enum logic [3:0] {
		MPMC_ST_RESET = 4'h1,
		MPMC_ST_LOW = 4'h2,
		MPMC_ST_HIGH = 4'h4,
		MPMC_ST_DROP = 4'h8
	} mpmc_state_t;

	typedef struct packed {
		logic force_low_power_bit;
		logic tx_hold_off;
	} mpmc_ctrl_t;

	typedef struct packed {
		logic in_reset;
		logic low_power;
		logic high_power;
		logic tx_enable;
	} mpmc_stat_t;
endpackage

/* File: mpmc_properties.sv */
// Port checker for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module mpmc_checker #(
	parameter logic [2:0] POWER_CLASS = 3'h3
) (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Reset
	input wire logic module_reset_in_n, // Reset pin
	input wire logic module_low_power_in_n, // Low-power pin
	input wire logic hsel, // Select
	input wire logic [11:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer
	input wire logic hwrite, // Write
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Ready
	input wire logic [31:0] hrdata, // Read data
	input wire logic tx_enable, // Tx on
	input wire logic high_power_en, // High power
	input wire logic in_reset // Reset state
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Taken address phases
	sequence s_take;
		hsel && hready && htrans == 2'h2;
	endsequence
	sequence s_ctrl_wr;
		s_take and hwrite && haddr == 12'h000;
	endsequence
	sequence s_ctrl_rd;
		s_take and !hwrite && haddr == 12'h000;
	endsequence
	a_lp_pin_off: assert property (!module_low_power_in_n [*5] |-> !tx_enable && !high_power_en)
		else $error("tx on while low power requested");
	a_high_needs_pins: assert property (high_power_en |-> $past(module_reset_in_n, 3) && $past(module_low_power_in_n, 3))
		else $error("high power without released pins");
	a_drop_prompt: assert property ($fell(module_low_power_in_n) || $fell(module_reset_in_n) |-> ##[1:4] !high_power_en)
		else $error("slow drop to low power");
	a_tx_only_high: assert property (tx_enable |-> high_power_en)
		else $error("tx on outside high power");
	a_reset_quiet: assert property (in_reset |-> !high_power_en && !tx_enable)
		else $error("reset state not quiet");
	a_flp_blocks: assert property (s_ctrl_wr ##1 hwdata[0] |-> ##3 !high_power_en)
		else $error("force bit ignored");
	a_hold_blocks: assert property (s_ctrl_wr ##1 hwdata[1] |-> ##3 !tx_enable)
		else $error("tx hold-off ignored");
	a_class_read: assert property (s_take and !hwrite && haddr == 12'h008 |=> hrdata == {29'h0, POWER_CLASS})
		else $error("bad class read");
	a_ctrl_restored: assert property (in_reset && $past(in_reset) ##0 s_ctrl_rd |=> hrdata[1:0] == 2'h0)
		else $error("control not at default in reset");
endmodule
bind mpmc_top mpmc_checker #(.POWER_CLASS(POWER_CLASS)) mpmc_checker_inst (.mclk, .rst_n,
	.module_reset_in_n, .module_low_power_in_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .tx_enable, .high_power_en, .in_reset);
`default_nettype wire

/* File: mpmc_sync.sv */
// Two-stage synchroniser for the sideband inputs
`timescale 1ns/10ps
`default_nettype none
module mpmc_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic mclk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [WIDTH-1:0] d, // Asynchronous inputs
	output logic [WIDTH-1:0] q // Synchronised outputs
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* File: mpmc_top.sv */
// Power mode controller with AHB-Lite register slave
// Summary of operation
// RULE_01: Every power-up or insertion starts from reset state via the power-on reset.
// RULE_02: Force-low-power bit leaves power-up holding its manufactured default, normally zero.
// RULE_03: Host may write the bit; reset or power cycle restores the default.
// RULE_04: Low-power request low forces low power mode, transmitters off.
// RULE_05: Request high and force bit clear enables transmitters at once.
// RULE_06: Request high with force bit set stays low power until cleared.
// RULE_07: Host may override transmitter enable on entering operational state.
// RULE_08: Module reset input overrides everything, forcing reset, low power, transmitters off.
// RULE_09: In reset or low power mode consumption stays within class one.
// RULE_10: High power permits drawing up to the advertised class, host decides.
// RULE_11: Host may read the power class indication at any time.
// RULE_12: Module never exceeds the class it reports.
// RULE_13: Reset, low-power request or force bit puts module in low power.
// RULE_14: High power only once reset, request and force bit are all clear.
// RULE_15: High to low power transition completes within 200 microseconds.
// RULE_16: Reported power class is one of eight classes.
// RULE_17: Reset request arrives active low as module reset input.
// RULE_18: Low-power request arrives active low as module low-power input.
// RULE_19: Reset and low-power inputs are synchronised before selecting state.
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`include "mpmc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module mpmc_top
	import mpmc_pkg::*;
#(
	parameter int HPLP_CYCLES = `MPMC_HPLP_CYCLES,
	parameter int DROP_CYCLES = `MPMC_DROP_CYCLES,
	parameter logic [2:0] POWER_CLASS = `MPMC_POWER_CLASS
) (
	input wire logic mclk, // 200 MHz clock
	input wire logic rst_n, // Power-on reset, active low
	input wire logic module_reset_in_n, // Module reset sideband, active low
	input wire logic module_low_power_in_n, // Low-power request sideband, active low
	input wire logic hsel, // AHB slave select
	input wire logic [11:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response
	output logic tx_enable, // Transmitters enabled
	output logic high_power_en, // High power supply allowed
	output logic in_reset, // Module held in reset
	output logic drop_done // Last drop to low power met its deadline
);
	// Sideband levels, raw and synchronised
	logic [1:0] sync_in;
	logic [1:0] sync_out;
	logic mod_reset_n;
	logic low_power_request_n;

	// Control register and power state
	mpmc_ctrl_t ctrl_q;
	mpmc_state_t state_q;
	mpmc_state_t state_d;
	logic want_low;
	logic want_reset;

	// Drop timing
	logic [31:0] drop_cnt_q;
	logic drop_over;
	logic drop_leave;
	logic drop_done_q;

	// Power class code
	logic [2:0] class_q;

	// Bus decode and read path
	logic addr_take;
	logic wr_take;
	logic rd_take;
	logic wr_pend_q;
	logic [11:0] wr_addr_q;
	logic wr_strobe;
	logic ctrl_wr;
	logic [31:0] rd_word;
	mpmc_stat_t stat;

	// Word-aligned address compare
	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
		addr_is = (a[11:2] == off[11:2]);
	endfunction

	// Transfer type that opens a transfer
	function automatic logic is_nonseq(input logic [1:0] t);
		is_nonseq = (t == `MPMC_HTRANS_NONSEQ);
	endfunction

	// Only the high state may draw above class one
	function automatic logic is_high(input mpmc_state_t s);
		is_high = (s == MPMC_ST_HIGH);
	endfunction

	// Reset state decode
	function automatic logic is_reset(input mpmc_state_t s);
		is_reset = (s == MPMC_ST_RESET);
	endfunction

	// Drop state decode
	function automatic logic is_drop(input mpmc_state_t s);
		is_drop = (s == MPMC_ST_DROP);
	endfunction

	// Control register as a bus word
	function automatic logic [31:0] ctrl_word(input mpmc_ctrl_t c);
		ctrl_word = 32'h0000_0000;
		ctrl_word[`MPMC_CTRL_FLP_BIT] = c.force_low_power_bit;
		ctrl_word[`MPMC_CTRL_TXOVR_BIT] = c.tx_hold_off;
	endfunction

	// RULE_17: active-low reset pin
	// RULE_18: active-low request pin
	assign sync_in = {module_reset_in_n, module_low_power_in_n};

	// RULE_19: two-flop synchronisers
	mpmc_sync #(
		.WIDTH(2),
		.INIT(2'h0)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(sync_in),
		.q(sync_out)
	);

	// Synchronised levels, still active low
	assign mod_reset_n = sync_out[1];
	assign low_power_request_n = sync_out[0];

	// Reset pin held low asks for reset
	assign want_reset = !mod_reset_n;

	// RULE_13: any low-power cause
	// RULE_06: force bit keeps low
	assign want_low = !low_power_request_n || ctrl_q.force_low_power_bit;

	// Address phase qualifiers
	assign addr_take = hready && hsel && is_nonseq(htrans);
	assign wr_take = addr_take && hwrite;
	assign rd_take = addr_take && !hwrite;

	// Address phase capture for writes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
		end else if (hready) begin
			wr_pend_q <= wr_take;
		end
	end

	// Write address held into the data phase
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_addr_q <= 12'h000;
		end else if (hready) begin
			wr_addr_q <= haddr;
		end
	end

	// Data phase completes only with ready high
	assign wr_strobe = wr_pend_q && hready;
	assign ctrl_wr = wr_strobe && addr_is(wr_addr_q, `MPMC_ADDR_CTRL);

	// Control register, restored by either reset
	always_ff @(posedge mclk) begin
		if (!rst_n || want_reset) begin
			// RULE_02: manufactured default
			// RULE_03: default on reset
			ctrl_q.force_low_power_bit <= `MPMC_FLP_DEFAULT;
			ctrl_q.tx_hold_off <= `MPMC_TXOVR_DEFAULT;
		end else if (ctrl_wr) begin
			ctrl_q.force_low_power_bit <= hwdata[`MPMC_CTRL_FLP_BIT];
			ctrl_q.tx_hold_off <= hwdata[`MPMC_CTRL_TXOVR_BIT];
		end
	end

	// Power class is loaded after reset release
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			class_q <= `MPMC_CLASS_DEFAULT;
		end else begin
			// RULE_16: three-bit class code
			class_q <= POWER_CLASS;
		end
	end

	// Drop state has run its length
	assign drop_over = (drop_cnt_q >= 32'(DROP_CYCLES - 1));

	// Next-state logic
	always_comb begin
		state_d = state_q;
		case (state_q)
			MPMC_ST_RESET: begin
				if (!want_reset) begin
					state_d = MPMC_ST_LOW;
				end
			end
			MPMC_ST_LOW: begin
				// RULE_14: all causes clear
				// RULE_05: go at once
				if (!want_low) begin
					state_d = MPMC_ST_HIGH;
				end
			end
			MPMC_ST_HIGH: begin
				// RULE_15: begin timed drop
				if (want_low) begin
					state_d = MPMC_ST_DROP;
				end
			end
			MPMC_ST_DROP: begin
				if (drop_over) begin
					state_d = MPMC_ST_LOW;
				end
			end
			default: begin
				state_d = MPMC_ST_RESET;
			end
		endcase
		// RULE_08: reset overrides all
		if (want_reset) begin
			state_d = MPMC_ST_RESET;
		end
	end

	// RULE_01: power-up starts in reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= MPMC_ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// Drop timer, cleared outside the drop state
	always_ff @(posedge mclk) begin
		if (!rst_n || !is_drop(state_q)) begin
			drop_cnt_q <= 32'h0000_0000;
		end else begin
			drop_cnt_q <= drop_cnt_q + 32'h0000_0001;
		end
	end

	// Leaving the drop state, by timer or reset
	assign drop_leave = is_drop(state_q) && !is_drop(state_d);

	// RULE_15: deadline check
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			drop_done_q <= 1'b1;
		end else if (drop_leave) begin
			drop_done_q <= (drop_cnt_q < 32'(HPLP_CYCLES));
		end
	end
	assign drop_done = drop_done_q;

	// Transmitter enable, off at once on any drop
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_enable <= 1'b0;
		end else begin
			// RULE_04: tx off in low
			// RULE_07: host hold-off honoured
			tx_enable <= is_high(state_d) && !ctrl_q.tx_hold_off;
		end
	end

	// High power supply permit
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			high_power_en <= 1'b0;
		end else begin
			// RULE_09: class one outside high
			// RULE_10: high power when allowed
			// RULE_12: tied to state
			high_power_en <= is_high(state_d);
		end
	end

	// Reset state flag
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			in_reset <= 1'b1;
		end else begin
			in_reset <= is_reset(state_d);
		end
	end

	// Status word from the registered outputs
	assign stat = {in_reset, !high_power_en, high_power_en, tx_enable};

	// Read data select, unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (addr_is(haddr, `MPMC_ADDR_CTRL)) begin
			rd_word = ctrl_word(ctrl_q);
		end else if (addr_is(haddr, `MPMC_ADDR_STATUS)) begin
			rd_word = {28'h0, stat};
		end else if (addr_is(haddr, `MPMC_ADDR_CLASS)) begin
			// RULE_11: class readable
			rd_word = {29'h0, class_q};
		end
	end

	// Read data registered for the data phase
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_take) begin
			hrdata <= rd_word;
		end
	end

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Testbench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, want_rst = 1'b1, want_lp = 1'b1;
	logic rd_ph = 1'b0, r, l, f, h, hreadyout, hresp, tx_enable, high_power_en, in_reset;
	logic rst_pin_n, lp_pin_n, drop_done;
	logic [3:0] lag = 4'h0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic [63:0] notes[$];
	int mismatches = 0, n_checks = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	mpmc_host_model mpmc_host_model_inst (.mclk(mclk), .want_rst(want_rst), .want_lp(want_lp),
		.lag(lag), .module_reset_in_n(rst_pin_n), .module_low_power_in_n(lp_pin_n));
	mpmc_top #(.HPLP_CYCLES(64), .DROP_CYCLES(4), .POWER_CLASS(3'h5)) mpmc_top_inst (
		.mclk(mclk), .rst_n(rst_n), .module_reset_in_n(rst_pin_n), .module_low_power_in_n(lp_pin_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .tx_enable(tx_enable), .high_power_en(high_power_en),
		.in_reset(in_reset), .drop_done(drop_done));
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cmp_word(input logic [31:0] exp, msk, seen);
		n_checks++;
		if ((seen & msk) !== (exp & msk)) begin
			mismatches++;
			$display("MISMATCH hrdata exp %h seen %h", exp & msk, seen & msk);
		end
	endtask
	task automatic cmp_bit(input string nm, input logic exp, seen);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %b seen %b", nm, exp, seen);
		end
	endtask
	// One single-word transfer; reads leave a note
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, msk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		if (!wr) notes.push_back({msk, d});
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	// Oldest note against each read data phase
	always @(posedge mclk) begin
		if (rd_ph && hreadyout === 1'b1 && notes.size() > 0) begin
			cmp_word(notes[0][31:0], notes[0][63:32], hrdata);
			cmp_bit("hresp", 1'b0, hresp);
			void'(notes.pop_front());
		end
	end
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			close_out();
		end
	end
	initial begin
		void'($urandom(45));
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		bus(1'b0, 12'h000, 32'h0, '1);
		bus(1'b0, 12'h008, 32'h5, '1);
		bus(1'b1, 12'h0fc, 32'h3, '1);
		bus(1'b0, 12'h0fc, 32'h0, '1);
		for (int i = 0; i < 40; i++) begin
			{r, l, f, h} = (i < 16) ? 4'(i) : 4'($urandom());
			lag <= {2'h0, 2'($urandom())};
			want_rst <= r;
			want_lp <= l;
			repeat (12) @(posedge mclk);
			bus(1'b1, 12'h000, {30'h0, h, f}, '1);
			repeat (30) @(posedge mclk);
			cmp_bit("in_reset", r, in_reset);
			cmp_bit("high_power_en", !r && !l && !f, high_power_en);
			cmp_bit("tx_enable", !r && !l && !f && !h, tx_enable);
			cmp_bit("drop_done", 1'b1, drop_done);
			bus(1'b0, 12'h004, r ? 32'h8 : (l || f) ? 32'h4 : {30'h0, 1'b1, !h}, r ? 32'hb : 32'hf);
			bus(1'b0, 12'h000, r ? 32'h0 : {30'h0, h, f}, 32'h3);
			$display("test %0d done", i);
		end
		close_out();
	end
endmodule
`default_nettype wire
